// ---- logic/cfsw_map.vh ----
// Purpose: Constants for the CPU frequency select and watchdog recovery block
// Assumes: Byte-wide register port driven by an SMBus engine on MCLK_I
// Notes: Offsets are byte indices of the control-byte space

`ifndef CFSW_MAP_VH
`define CFSW_MAP_VH

// Register byte offsets
`define CFSW_OFS_CTRL       8'h00
`define CFSW_OFS_CPU_NUM    8'h01
`define CFSW_OFS_CPU_DEN    8'h02
`define CFSW_OFS_REC_NUM    8'h03
`define CFSW_OFS_REC_DEN    8'h04
`define CFSW_OFS_WDOG       8'h05
`define CFSW_OFS_RSTCTL     8'h06
`define CFSW_OFS_STATUS     8'h07
`define CFSW_OFS_SPARE_A    8'h10
`define CFSW_OFS_SPARE_B    8'h11

// Control byte fields
`define CFSW_CTRL_PROG_BIT  7
`define CFSW_CTRL_BYP_BIT   6
`define CFSW_CTRL_RSRC_BIT  5
// Watchdog byte fields
`define CFSW_WD_RUN_BIT     7
`define CFSW_WD_FLAG_BIT    6
`define CFSW_WD_TSEL_BIT    5
// Reset control byte fields
`define CFSW_RST_WD_BIT     7
`define CFSW_RST_FC_BIT     6
// Status byte fields
`define CFSW_STAT_REC_BIT   7

// Reset values
`define CFSW_RST_BYTE       8'h00
`define CFSW_RST_CODE       5'h00
`define CFSW_RST_WDVAL      5'h00

// Timing
`define CFSW_CLK_HZ         100000000
`define CFSW_WD_SHORT_US    150000
`define CFSW_WD_LONG_US     2500000
`define CFSW_WD_SHORT_CYC   28'h0E4_E1C0
`define CFSW_WD_LONG_CYC    28'hEE6_B280
`define CFSW_RST_PULSE_CYC  8'h10
`define CFSW_STRAP_SETTLE   2'h3

`endif

// ---- logic/cfsw_top.v ----
// Purpose: Frequency selection and watchdog recovery control for a clock generator
// Assumes: SMBus engine on MCLK_I presents byte writes and reads; straps are async pins
// Notes: Frequencies are reported in units of 0.1 MHz; the PLL itself is outside

`timescale 1ns/100ps

`include "cfsw_map.vh"

module cfsw_top #(
   parameter [27:0] WD_SHORT_CYCLES = `CFSW_WD_SHORT_CYC,
   parameter [27:0] WD_LONG_CYCLES = `CFSW_WD_LONG_CYC,
   parameter [7:0] RST_PULSE_CYCLES = `CFSW_RST_PULSE_CYC
) (
   input wire MCLK_I,
   input wire SRST_I,
   input wire [4:0] STRAP_I,
   input wire REG_WR_I,
   input wire [7:0] REG_ADDR_I,
   input wire [7:0] REG_WDATA_I,
   output reg [7:0] REG_RDATA_O,
   output reg CPU_PROG_O,
   output reg [7:0] CPU_NUM_O,
   output reg [6:0] CPU_DEN_O,
   output reg [4:0] RATIO_CODE_O,
   output reg [11:0] CPU_FREQ_O,
   output reg [9:0] MID_FREQ_O,
   output reg [8:0] PCI_FREQ_O,
   output reg CODE_RSVD_O,
   output reg FREQ_LOAD_O,
   output reg RECOVERY_O,
   output reg WD_EXPIRED_O,
   output reg SYS_RESET_O
);

////////////////////////////////////////////////////////////////////////////////

localparam WD_IDLE = 2'b00;
localparam WD_ARMED = 2'b01;
localparam WD_COUNT = 2'b10;
localparam WD_DONE = 2'b11;

// Fixed rate table: {cpu, mid_speed_clock, pci} in 0.1 MHz, gear 48.00741 for all codes
function [30:0] rate_of;
   input [4:0] code;
   begin
      case (code)
         5'h00: rate_of = {12'h618, 10'h30C, 9'h186};
         5'h01: rate_of = {12'h604, 10'h302, 9'h181};
         5'h02: rate_of = {12'h5F0, 10'h2F8, 9'h17C};
         5'h03: rate_of = {12'h5BE, 10'h2DF, 9'h170};
         5'h04: rate_of = {12'h5A0, 10'h2D0, 9'h168};
         5'h05: rate_of = {12'h58C, 10'h2C6, 9'h163};
         5'h06: rate_of = {12'h564, 10'h2B2, 9'h159};
         5'h07: rate_of = {12'h550, 10'h2A8, 9'h154};
         5'h08: rate_of = {12'h4D8, 10'h26C, 9'h136};
         5'h09: rate_of = {12'h4C4, 10'h262, 9'h131};
         5'h0A: rate_of = {12'h492, 10'h30C, 9'h186};
         5'h0B: rate_of = {12'h47E, 10'h2FF, 9'h17F};
         5'h0C: rate_of = {12'h46A, 10'h2F1, 9'h179};
         5'h0D: rate_of = {12'h438, 10'h2D0, 9'h168};
         5'h0E: rate_of = {12'h41A, 10'h2BC, 9'h15E};
         5'h0F: rate_of = {12'h3FC, 10'h2A8, 9'h154};
         5'h13: rate_of = {12'h7D0, 10'h29A, 9'h14D};
         5'h14: rate_of = {12'h76C, 10'h2F8, 9'h17C};
         5'h15: rate_of = {12'h708, 10'h2D0, 9'h168};
         5'h16: rate_of = {12'h6A4, 10'h2A8, 9'h154};
         5'h17: rate_of = {12'h5DC, 10'h2EE, 9'h177};
         5'h18: rate_of = {12'h578, 10'h2BC, 9'h15E};
         5'h19: rate_of = {12'h4B0, 10'h258, 9'h12C};
         5'h1A: rate_of = {12'h44C, 10'h2DD, 9'h14D};
         5'h1B: rate_of = {12'h29A, 10'h29A, 9'h14D};
         5'h1C: rate_of = {12'h7D0, 10'h29A, 9'h14D};
         5'h1D: rate_of = {12'h682, 10'h29A, 9'h14D};
         5'h1E: rate_of = {12'h3E8, 10'h29A, 9'h14D};
         5'h1F: rate_of = {12'h535, 10'h29A, 9'h14D};
         default: rate_of = 31'h0000_0000;
      endcase
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers

reg prog_enable;
reg strap_bypass_select;
reg recovery_source_select;
reg [4:0] sel_code;
reg [7:0] cpu_numerator;
reg [6:0] cpu_denominator;
reg [7:0] recovery_numerator;
reg [6:0] recovery_denominator;
reg watchdog_run;
reg watchdog_tick_select;
reg [4:0] watchdog_count_value;
reg reset_on_expiry_enable;
reg reset_on_retune_enable;
reg watchdog_expired_flag;
reg recovery_active;

wire wr_ctrl = REG_WR_I && (REG_ADDR_I == `CFSW_OFS_CTRL);
wire wr_cnum = REG_WR_I && (REG_ADDR_I == `CFSW_OFS_CPU_NUM);
wire wr_cden = REG_WR_I && (REG_ADDR_I == `CFSW_OFS_CPU_DEN);
wire wr_rnum = REG_WR_I && (REG_ADDR_I == `CFSW_OFS_REC_NUM);
wire wr_rden = REG_WR_I && (REG_ADDR_I == `CFSW_OFS_REC_DEN);
wire wr_wdog = REG_WR_I && (REG_ADDR_I == `CFSW_OFS_WDOG);
wire wr_rctl = REG_WR_I && (REG_ADDR_I == `CFSW_OFS_RSTCTL);
wire flag_clear = wr_wdog && REG_WDATA_I[`CFSW_WD_FLAG_BIT];
reg wd_expire;

always @(posedge MCLK_I) begin
   if (SRST_I) begin
      prog_enable <= 1'b0;
      strap_bypass_select <= 1'b0;
      recovery_source_select <= 1'b0;
      sel_code <= `CFSW_RST_CODE;
      cpu_numerator <= `CFSW_RST_BYTE;
      cpu_denominator <= 7'h00;
      recovery_numerator <= `CFSW_RST_BYTE;
      recovery_denominator <= 7'h00;
      watchdog_run <= 1'b0;
      watchdog_tick_select <= 1'b0;
      watchdog_count_value <= `CFSW_RST_WDVAL;
      reset_on_expiry_enable <= 1'b0;
      reset_on_retune_enable <= 1'b0;
   end else begin
      if (wr_ctrl) begin
         prog_enable <= REG_WDATA_I[`CFSW_CTRL_PROG_BIT];
         strap_bypass_select <= REG_WDATA_I[`CFSW_CTRL_BYP_BIT];
         recovery_source_select <= REG_WDATA_I[`CFSW_CTRL_RSRC_BIT];
         sel_code <= REG_WDATA_I[4:0];
      end
      if (wr_cnum) begin
         cpu_numerator <= REG_WDATA_I;
      end
      if (wr_cden) begin
         cpu_denominator <= REG_WDATA_I[6:0];
      end
      if (wr_rnum) begin
         recovery_numerator <= REG_WDATA_I;
      end
      if (wr_rden) begin
         recovery_denominator <= REG_WDATA_I[6:0];
      end
      if (wr_wdog) begin
         watchdog_run <= REG_WDATA_I[`CFSW_WD_RUN_BIT];
         watchdog_tick_select <= REG_WDATA_I[`CFSW_WD_TSEL_BIT];
         watchdog_count_value <= REG_WDATA_I[4:0];
      end
      if (wr_rctl) begin
         reset_on_expiry_enable <= REG_WDATA_I[`CFSW_RST_WD_BIT];
         reset_on_retune_enable <= REG_WDATA_I[`CFSW_RST_FC_BIT];
      end
   end
end

// Flag and recovery: set wins over a clear in the same cycle
always @(posedge MCLK_I) begin
   if (SRST_I) begin
      watchdog_expired_flag <= 1'b0;
      recovery_active <= 1'b0;
   end else if (wd_expire) begin
      watchdog_expired_flag <= 1'b1;
      recovery_active <= 1'b1;
   end else if (flag_clear) begin
      watchdog_expired_flag <= 1'b0;
      recovery_active <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Strap capture

reg [4:0] strap_meta;
reg [4:0] strap_sync;
reg [4:0] latched_code;
reg [1:0] strap_wait;
reg strap_taken;

always @(posedge MCLK_I) begin
   strap_meta <= STRAP_I;
   strap_sync <= strap_meta;
end

// Waits for the synchroniser to fill, then holds the value until the next reset
always @(posedge MCLK_I) begin
   if (SRST_I) begin
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
      latched_code <= `CFSW_RST_CODE;
   end else if (!strap_taken) begin
      if (strap_wait == `CFSW_STRAP_SETTLE) begin
         latched_code <= strap_sync;
         strap_taken <= 1'b1;
      end else begin
         strap_wait <= strap_wait + 2'h1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Frequency selection

reg next_prog;
reg [7:0] next_num;
reg [6:0] next_den;
reg [4:0] next_code;
reg [30:0] next_rate;
reg freq_change;
reg load_pending;

always @* begin
   next_code = strap_bypass_select ? sel_code : latched_code;
   next_prog = 1'b0;
   next_num = CPU_NUM_O;
   next_den = CPU_DEN_O;
   if (recovery_active && !recovery_source_select) begin
      next_code = latched_code;
   end else if (recovery_active) begin
      next_prog = 1'b1;
      next_num = recovery_numerator;
      next_den = recovery_denominator;
   end else if (prog_enable) begin
      next_prog = 1'b1;
      next_num = cpu_numerator;
      next_den = cpu_denominator;
   end
   next_rate = rate_of(next_code);
   freq_change = (next_prog != CPU_PROG_O) || (next_code != RATIO_CODE_O)
      || (next_prog && ((next_num != CPU_NUM_O) || (next_den != CPU_DEN_O)));
end

always @(posedge MCLK_I) begin
   if (SRST_I) begin
      CPU_PROG_O <= 1'b0;
      CPU_NUM_O <= `CFSW_RST_BYTE;
      CPU_DEN_O <= 7'h00;
      RATIO_CODE_O <= `CFSW_RST_CODE;
      CPU_FREQ_O <= 12'h000;
      MID_FREQ_O <= 10'h000;
      PCI_FREQ_O <= 9'h000;
      CODE_RSVD_O <= 1'b0;
      FREQ_LOAD_O <= 1'b0;
      load_pending <= 1'b0;
   end else begin
      CPU_PROG_O <= next_prog;
      CPU_NUM_O <= next_num;
      CPU_DEN_O <= next_den;
      RATIO_CODE_O <= next_code;
      CPU_FREQ_O <= next_rate[30:19];
      MID_FREQ_O <= next_rate[18:9];
      PCI_FREQ_O <= next_rate[8:0];
      CODE_RSVD_O <= (next_rate == 31'h0000_0000);
      // Rewriting an unchanged value still reloads, so the host can force a load;
      // held a cycle so one write gives one pulse, on the edge that moves the outputs
      load_pending <= ((wr_cnum || wr_cden) && prog_enable && !recovery_active)
         || ((wr_rnum || wr_rden) && recovery_active && recovery_source_select);
      FREQ_LOAD_O <= freq_change || load_pending;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Watchdog

reg [1:0] wd_state;
reg [4:0] wd_count;
reg [27:0] wd_tick;
wire [27:0] tick_last = (watchdog_tick_select ? WD_LONG_CYCLES : WD_SHORT_CYCLES) - 28'h1;

always @(posedge MCLK_I) begin
   if (SRST_I) begin
      wd_state <= WD_IDLE;
      wd_count <= `CFSW_RST_WDVAL;
      wd_tick <= 28'h000_0000;
      wd_expire <= 1'b0;
   end else begin
      wd_expire <= 1'b0;
      if (!watchdog_run) begin
         wd_state <= WD_IDLE;
         wd_count <= watchdog_count_value;
         wd_tick <= 28'h000_0000;
      end else begin
         case (wd_state)
            WD_IDLE: begin
               wd_state <= WD_ARMED;
            end
            WD_ARMED: begin
               if (FREQ_LOAD_O) begin
                  wd_state <= WD_COUNT;
                  wd_count <= watchdog_count_value;
                  wd_tick <= 28'h000_0000;
               end
            end
            WD_COUNT: begin
               if (wd_tick == tick_last) begin
                  wd_tick <= 28'h000_0000;
                  // A value of zero expires at the first step
                  if (wd_count <= 5'h01) begin
                     wd_count <= 5'h00;
                     wd_state <= WD_DONE;
                     wd_expire <= 1'b1;
                  end else begin
                     wd_count <= wd_count - 5'h01;
                  end
               end else begin
                  wd_tick <= wd_tick + 28'h000_0001;
               end
            end
            WD_DONE: begin
               wd_state <= WD_DONE;
            end
            default: begin
               wd_state <= WD_IDLE;
            end
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Reset pulse

reg [7:0] rst_left;
wire rst_trigger = (wd_expire && reset_on_expiry_enable)
   || (FREQ_LOAD_O && reset_on_retune_enable);

always @(posedge MCLK_I) begin
   if (SRST_I) begin
      rst_left <= 8'h00;
      SYS_RESET_O <= 1'b0;
   end else if (rst_left != 8'h00) begin
      rst_left <= rst_left - 8'h01;
      SYS_RESET_O <= (rst_left != 8'h01);
   end else if (rst_trigger) begin
      rst_left <= RST_PULSE_CYCLES;
      SYS_RESET_O <= 1'b1;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read-back

always @(posedge MCLK_I) begin
   if (SRST_I) begin
      REG_RDATA_O <= 8'h00;
      RECOVERY_O <= 1'b0;
      WD_EXPIRED_O <= 1'b0;
   end else begin
      RECOVERY_O <= recovery_active;
      WD_EXPIRED_O <= watchdog_expired_flag;
      case (REG_ADDR_I)
         `CFSW_OFS_CTRL: REG_RDATA_O <= {prog_enable, strap_bypass_select,
            recovery_source_select, sel_code};
         `CFSW_OFS_CPU_NUM: REG_RDATA_O <= cpu_numerator;
         `CFSW_OFS_CPU_DEN: REG_RDATA_O <= {1'b0, cpu_denominator};
         `CFSW_OFS_REC_NUM: REG_RDATA_O <= recovery_numerator;
         `CFSW_OFS_REC_DEN: REG_RDATA_O <= {1'b0, recovery_denominator};
         `CFSW_OFS_WDOG: REG_RDATA_O <= {watchdog_run, watchdog_expired_flag,
            watchdog_tick_select, watchdog_count_value};
         `CFSW_OFS_RSTCTL: REG_RDATA_O <= {reset_on_expiry_enable,
            reset_on_retune_enable, 6'h00};
         `CFSW_OFS_STATUS: REG_RDATA_O <= {recovery_active, 2'h0, latched_code};
         `CFSW_OFS_SPARE_A: REG_RDATA_O <= 8'h00;
         `CFSW_OFS_SPARE_B: REG_RDATA_O <= 8'h00;
         default: REG_RDATA_O <= 8'h00;
      endcase
   end
end

endmodule

// ---- testbench/cfsw_properties.sv ----
// Purpose: Port checks for the frequency select and watchdog block
// Assumes: One clock domain, synchronous active-high reset
// Notes: Pulse length is counted in helper logic, not unrolled
`timescale 1ns/100ps
module cfsw_properties #(
   parameter [7:0] RST_PULSE_CYCLES = 8'h10
) (
   input wire MCLK_I,
   input wire SRST_I,
   input wire REG_WR_I,
   input wire [7:0] REG_ADDR_I,
   input wire [7:0] REG_WDATA_I,
   input wire [7:0] REG_RDATA_O,
   input wire CPU_PROG_O,
   input wire [7:0] CPU_NUM_O,
   input wire FREQ_LOAD_O,
   input wire RECOVERY_O,
   input wire WD_EXPIRED_O,
   input wire SYS_RESET_O
);
   default clocking @(posedge MCLK_I);
   endclocking
   default disable iff (SRST_I);
   logic [7:0] hi_cnt;
   logic [2:0] ctl_wr;
   logic [1:0] clr_wr;
   ////////////////////////////////////////////////////////////
   always @(posedge MCLK_I) begin
      if (SRST_I) begin
         hi_cnt <= 8'h00;
         ctl_wr <= 3'h0;
         clr_wr <= 2'h0;
      end else begin
         hi_cnt <= SYS_RESET_O ? hi_cnt + 8'h01 : 8'h00;
         ctl_wr <= {ctl_wr[1:0], REG_WR_I && REG_ADDR_I == 8'h00};
         clr_wr <= {clr_wr[0], REG_WR_I && REG_ADDR_I == 8'h05 && REG_WDATA_I[6]};
      end
   end
   ////////////////////////////////////////////////////////////
   sequence s_num_wr;
      REG_WR_I && REG_ADDR_I == 8'h01 && CPU_PROG_O && !RECOVERY_O;
   endsequence
   sequence s_load_soon;
      ##[0:3] FREQ_LOAD_O;
   endsequence
   property p_num_load;
      s_num_wr |-> ##2 FREQ_LOAD_O && CPU_NUM_O == $past(REG_WDATA_I, 2);
   endproperty
   a_num_load: assert property (p_num_load) else $error("numerator write not loaded");
   property p_spare_zero;
      REG_ADDR_I == 8'h10 || REG_ADDR_I == 8'h11 |=> REG_RDATA_O == 8'h00;
   endproperty
   a_spare_zero: assert property (p_spare_zero) else $error("spare byte not zero");
   property p_pulse_len;
      $fell(SYS_RESET_O) |-> hi_cnt == RST_PULSE_CYCLES;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length off");
   property p_pulse_max;
      SYS_RESET_O |-> hi_cnt < RST_PULSE_CYCLES;
   endproperty
   a_pulse_max: assert property (p_pulse_max) else $error("reset pulse extended");
   // Recovery may move the mode by itself: recovery seen two cycles back, now, or one cycle ahead
   property p_prog_src;
      $changed(CPU_PROG_O) |-> (ctl_wr[1] || ctl_wr[2] || $past(RECOVERY_O, 2))
         or (##[0:1] RECOVERY_O);
   endproperty
   a_prog_src: assert property (p_prog_src) else $error("mode moved without cause");
   property p_flag_clr;
      $fell(WD_EXPIRED_O) |-> clr_wr[1];
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag fell without clear");
   property p_exp_rec;
      $rose(WD_EXPIRED_O) |-> RECOVERY_O;
   endproperty
   a_exp_rec: assert property (p_exp_rec) else $error("expiry without recovery");
   property p_rec_load;
      $rose(RECOVERY_O) |-> s_load_soon;
   endproperty
   a_rec_load: assert property (p_rec_load) else $error("recovery not loaded");
endmodule

// ---- testbench/cfsw_host.sv ----
// Purpose: Firmware-driven SMBus host as seen at the byte register port
// Assumes: Each byte is a one-cycle strobe on the block clock
// Notes: Released data lines show the inverse of the last byte
`timescale 1ns/100ps
module cfsw_host (
   input wire clk_i,
   input wire [7:0] rdata_i,
   output logic wr_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   initial begin
      wr_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   ////////////////////////////////////////////////////////////
   task wr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, input bit word);
      @(posedge clk_i) #1;
      wr_o = 1'b1;
      addr_o = a;
      wdata_o = d0;
      if (word) begin
         @(posedge clk_i) #1;
         addr_o = a + 8'h01;
         wdata_o = d1;
      end
      @(posedge clk_i) #1;
      wr_o = 1'b0;
      wdata_o = ~wdata_o;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i) #1;
      addr_o = a;
      @(posedge clk_i) #1;
      d = rdata_i;
   endtask
endmodule

// ---- testbench/cfsw_top_test.sv ----
// Purpose: Self-checking bench for the frequency select and watchdog block
// Assumes: Short watchdog ticks and reset pulse set by parameters
// Notes: Straps move after latching to show they are held
`timescale 1ns/100ps
module cfsw_top_test;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [4:0] strap = 5'h1f;
   logic wr;
   logic [7:0] addr, wdata;
   wire [7:0] rdata, num;
   wire [6:0] den;
   wire [4:0] code;
   wire [11:0] cpu_f;
   wire [9:0] mid_f;
   wire [8:0] pci_f;
   wire prog, rsvd, load, rec, expd, sysrst;
   integer num_errors, comparisons, n, l0, r0;
   integer loads = 0;
   integer rsts = 0;
   integer cyc_cnt = 0;
   always #5 clk = ~clk;
   cfsw_host host (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
   cfsw_top #(.WD_SHORT_CYCLES(28'h14), .WD_LONG_CYCLES(28'h32), .RST_PULSE_CYCLES(8'h08)) uut (
      .MCLK_I(clk), .SRST_I(srst), .STRAP_I(strap), .REG_WR_I(wr), .REG_ADDR_I(addr),
      .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .CPU_PROG_O(prog), .CPU_NUM_O(num),
      .CPU_DEN_O(den), .RATIO_CODE_O(code), .CPU_FREQ_O(cpu_f), .MID_FREQ_O(mid_f),
      .PCI_FREQ_O(pci_f), .CODE_RSVD_O(rsvd), .FREQ_LOAD_O(load), .RECOVERY_O(rec),
      .WD_EXPIRED_O(expd), .SYS_RESET_O(sysrst));
   ////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (load)
         loads <= loads + 1;
      if ($rose(sysrst))
         rsts <= rsts + 1;
   end
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task complete_run;
      if (num_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task cyc(input integer k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task w(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d, 8'h00, 1'b0);
   endtask
   task r(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host.rd(a, v);
      cmp(v, exp);
   endtask
   // Bounded wait for expiry or a load; a miss is a mismatch
   task wt(input bit on_exp, input integer lim);
      n = 0;
      while ((on_exp ? expd : load) !== 1'b1 && n < lim) begin
         cyc(1);
         n = n + 1;
      end
      cmp(n < lim, 1'b1);
   endtask
   task tbl(input logic [4:0] c, input logic [31:0] e);
      w(8'h00, {3'b010, c});
      wt(1'b0, 10);
      cyc(3);
      cmp({rsvd, cpu_f, mid_f, pci_f}, e);
      cmp(code, c);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      num_errors = 0;
      comparisons = 0;
      cyc(8);
      srst = 1'b0;
      fork
         begin
            wait (cyc_cnt >= 5000);
            num_errors = num_errors + 1;
         end
      begin
      cyc(8);
      strap = 5'h0a;
      r(8'h07, 8'h1f);
      r(8'h00, 8'h00);
      cmp({prog, code, cpu_f}, {1'b0, 5'h1f, 12'h535});
      w(8'h10, 8'hff);
      w(8'h11, 8'hff);
      w(8'h20, 8'hff);
      r(8'h10, 8'h00);
      r(8'h11, 8'h00);
      r(8'h20, 8'h00);
      tbl(5'h00, {1'b0, 12'h618, 10'h30c, 9'h186});
      tbl(5'h0a, {1'b0, 12'h492, 10'h30c, 9'h186});
      tbl(5'h10, {1'b1, 31'h0});
      tbl(5'h12, {1'b1, 31'h0});
      tbl(5'h13, {1'b0, 12'h7d0, 10'h29a, 9'h14d});
      tbl(5'h1b, {1'b0, 12'h29a, 10'h29a, 9'h14d});
      w(8'h00, 8'h13);
      wt(1'b0, 10);
      cyc(3);
      cmp(code, 5'h1f);
      w(8'h00, 8'h80);
      wt(1'b0, 10);
      cyc(3);
      cmp({prog, code}, {1'b1, 5'h1f});
      w(8'h06, 8'h40);
      l0 = loads;
      r0 = rsts;
      host.wr(8'h01, 8'hc8, 8'h30, 1'b1);
      cyc(12);
      cmp(loads - l0, 32'h2);
      cmp(rsts - r0, 32'h1);
      cmp({num, den}, {8'hc8, 7'h30});
      host.wr(8'h01, 8'h61, 8'h5d, 1'b1);
      cyc(4);
      cmp({num, den}, {8'h61, 7'h5d});
      w(8'h00, 8'hd3);
      wt(1'b0, 10);
      cyc(12);
      cmp({prog, code}, {1'b1, 5'h13});
      w(8'h03, 8'h80);
      w(8'h04, 8'h40);
      w(8'h00, 8'hf3);
      w(8'h06, 8'h80);
      w(8'h05, 8'h81);
      cyc(40);
      cmp(expd, 1'b0);
      r0 = rsts;
      w(8'h01, 8'hd0);
      wt(1'b1, 40);
      cmp(n >= 20 && n <= 26, 1'b1);
      cyc(4);
      cmp({rec, prog, num, den}, {2'b11, 8'h80, 7'h40});
      cmp(code, 5'h13);
      cmp(rsts - r0, 32'h1);
      r(8'h05, 8'hc1);
      r(8'h07, 8'h9f);
      l0 = loads;
      w(8'h03, 8'h90);
      cyc(3);
      cmp(loads - l0, 32'h1);
      cmp(num, 8'h90);
      w(8'h05, 8'h41);
      cyc(4);
      cmp({expd, rec}, 2'b00);
      w(8'h06, 8'h00);
      w(8'h00, 8'hd3);
      w(8'h05, 8'ha0);
      r0 = rsts;
      w(8'h01, 8'h64);
      wt(1'b1, 80);
      cmp(n >= 50 && n <= 56, 1'b1);
      cyc(4);
      cmp({rec, prog, code}, {2'b10, 5'h1f});
      cmp(rsts - r0, 32'h0);
      w(8'h05, 8'h40);
      w(8'h05, 8'h81);
      w(8'h01, 8'h70);
      cyc(10);
      w(8'h05, 8'h01);
      cyc(40);
      cmp(expd, 1'b0);
      end
      join_any
      complete_run;
   end
endmodule
bind cfsw_top cfsw_properties #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) chk (
   .MCLK_I(MCLK_I), .SRST_I(SRST_I), .REG_WR_I(REG_WR_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .CPU_PROG_O(CPU_PROG_O),
   .CPU_NUM_O(CPU_NUM_O), .FREQ_LOAD_O(FREQ_LOAD_O), .RECOVERY_O(RECOVERY_O),
   .WD_EXPIRED_O(WD_EXPIRED_O), .SYS_RESET_O(SYS_RESET_O));
